/* File: verilog/csc_conversion_sequencer.sv */
// conversion sequencer: rate, channel enables, filter select, one-shot and busy

// Operation
// - rate code 01, 10 and 11 give intervals of 0.364 s, 1 s and 2.5 s.
// - rate code 00 converts back to back, with only the single wait-state cycle between passes.
// - each interval converts enabled channels in turn, then waits out the rest.
// - a channel with its enable cleared is skipped and the next enabled one follows.
// - skipped channels lengthen the wait so timed intervals keep their length.
// - enable bits are remote two in bit 2, remote one in bit 1 and local in bit 0.
// - unused upper bits of the rate, enable and filter registers read as zero.
// - filter fields: bits 3-2 remote two, bits 1-0 remote one; 00 off, 01 basic, 11 enhanced.
// - a write to command 0x0f in standby while idle starts exactly one pass over enabled channels.
// - the one-shot command is write only and its data is neither used nor kept.
// - configuration bit 6 selects standby when one and periodic conversion when zero.
// - status bit 7 reports busy while a conversion runs.
// - extra fine result bits are enabled only while a remote filter is on.
module csc_conversion_sequencer
  import csc_pkg::*;
#(
  parameter int unsigned IVL_364_CYC = 32'(CSC_IVL_364_CYC),
  parameter int unsigned IVL_1S_CYC  = 32'(CSC_IVL_1S_CYC),
  parameter int unsigned IVL_2S5_CYC = 32'(CSC_IVL_2S5_CYC)
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_b,
  input  wire csc_reg_req_t i_reg_req,
  input  wire logic         i_conv_done,
  output logic [7:0]        o_reg_rdata,
  output logic              o_conv_start,
  output logic [1:0]        o_conv_chan,
  output logic              o_busy,
  output logic              o_standby,
  output logic [1:0]        o_rate_select,
  output logic [1:0]        o_remote_one_filter_sel,
  output logic [1:0]        o_remote_two_filter_sel,
  output logic [1:0]        o_fine_bits_en
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic                  standby_q,  standby_d;
  logic [CSC_RATE_W-1:0] rate_q,     rate_d;
  logic [CSC_CHAN_N-1:0] chan_en_q,  chan_en_d;
  logic [CSC_FILT_W-1:0] filt_q,     filt_d;
  logic [7:0]            rdata_q,    rdata_d;
  logic                  one_shot_wr;
  logic                  busy_q;

  always_comb begin
    standby_d   = standby_q;
    rate_d      = rate_q;
    chan_en_d   = chan_en_q;
    filt_d      = filt_q;
    rdata_d     = rdata_q;
    one_shot_wr = 1'b0;
    if (i_reg_req.wr) begin
      unique case (i_reg_req.cmd)
        CSC_CMD_CONFIG:   standby_d = i_reg_req.wdata[CSC_STANDBY_BIT];
        CSC_CMD_INTERVAL: rate_d    = i_reg_req.wdata[CSC_RATE_W-1:0];
        CSC_CMD_CHAN_EN:  chan_en_d = i_reg_req.wdata[CSC_CHAN_N-1:0];
        CSC_CMD_FILTER:   filt_d    = i_reg_req.wdata[CSC_FILT_W-1:0];
        CSC_CMD_ONE_SHOT: one_shot_wr = 1'b1;
        default:          ;
      endcase
    end
    if (i_reg_req.rd) begin
      rdata_d = 8'h00;
      unique case (i_reg_req.cmd)
        CSC_CMD_STATUS:   rdata_d[CSC_BUSY_BIT]    = busy_q;
        CSC_CMD_CONFIG:   rdata_d[CSC_STANDBY_BIT] = standby_q;
        CSC_CMD_INTERVAL: rdata_d[CSC_RATE_W-1:0]  = rate_q;
        CSC_CMD_CHAN_EN:  rdata_d[CSC_CHAN_N-1:0]  = chan_en_q;
        CSC_CMD_FILTER:   rdata_d[CSC_FILT_W-1:0]  = filt_q;
        default:          ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      standby_q <= CSC_CONFIG_RST[CSC_STANDBY_BIT];
      rate_q    <= CSC_INTERVAL_RST[CSC_RATE_W-1:0];
      chan_en_q <= CSC_CHAN_EN_RST[CSC_CHAN_N-1:0];
      filt_q    <= CSC_FILTER_RST[CSC_FILT_W-1:0];
      rdata_q   <= 8'h00;
    end else begin
      standby_q <= standby_d;
      rate_q    <= rate_d;
      chan_en_q <= chan_en_d;
      filt_q    <= filt_d;
      rdata_q   <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // lowest enabled channel at or above 'from'; bit 2 of the result flags a hit
  function automatic logic [2:0] next_chan(input logic [CSC_CHAN_N-1:0] en,
                                           input logic [2:0] from);
    logic [2:0] res;
    res = 3'h0;
    for (int i = CSC_CHAN_N - 1; i >= 0; i--) begin
      if (en[i] && (3'(i) >= from)) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] period_of(input logic [1:0] rate);
    logic [31:0] p;
    unique case (rate)
      CSC_RATE_364: p = IVL_364_CYC - 32'h1;
      CSC_RATE_1S:  p = IVL_1S_CYC - 32'h1;
      CSC_RATE_2S5: p = IVL_2S5_CYC - 32'h1;
      default:      p = 32'h0;
    endcase
    return p;
  endfunction

  csc_state_t  st_q,    st_d;
  logic [1:0]  ch_q,    ch_d;
  logic [31:0] ivl_q,   ivl_d;
  logic        start_q, start_d;
  logic        busy_d;
  logic        pass_go;
  logic        pass_end;
  logic [2:0]  nxt;

  always_comb begin
    st_d     = st_q;
    ch_d     = ch_q;
    start_d  = 1'b0;
    pass_go  = 1'b0;
    pass_end = 1'b0;
    nxt      = 3'h0;
    // interval timer runs from the start of a pass, so conversions and
    // skipped slots all fall inside it and the wait absorbs the rest
    ivl_d    = (ivl_q != 32'h0) ? ivl_q - 32'h1 : 32'h0;
    unique case (st_q)
      CSC_ST_IDLE: begin
        if (!standby_q) begin
          pass_go = 1'b1;
        end else if (one_shot_wr) begin
          pass_go = 1'b1;
        end
      end
      CSC_ST_CONV: begin
        if (i_conv_done) begin
          nxt = next_chan(chan_en_q, 3'(ch_q) + 3'h1);
          if (nxt[2]) begin
            ch_d    = nxt[1:0];
            start_d = 1'b1;
          end else begin
            pass_end = 1'b1;
          end
        end
      end
      CSC_ST_WAIT: begin
        // one-shot writes here are dropped; the schedule is untouched
        if (standby_q) begin
          st_d = CSC_ST_IDLE;
        end else if (ivl_q == 32'h0) begin
          pass_go = 1'b1;
        end
      end
      // the spare state code falls back to idle instead of locking up
      default:     st_d = CSC_ST_IDLE;
    endcase
    if (pass_go) begin
      ivl_d = period_of(rate_q);
      nxt   = next_chan(chan_en_q, 3'h0);
      if (nxt[2]) begin
        ch_d    = nxt[1:0];
        start_d = 1'b1;
        st_d    = CSC_ST_CONV;
      end else begin
        pass_end = 1'b1;
      end
    end
    if (pass_end) begin
      // standby ends after exactly one pass
      st_d = standby_q ? CSC_ST_IDLE : CSC_ST_WAIT;
    end
    busy_d = (st_d == CSC_ST_CONV);
  end

  always_ff @(posedge i_ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      st_q    <= CSC_ST_IDLE;
      ch_q    <= 2'h0;
      ivl_q   <= 32'h0;
      start_q <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      ch_q    <= ch_d;
      ivl_q   <= ivl_d;
      start_q <= start_d;
      busy_q  <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // fine bits follow the next filter value so they move on the same edge as the field;
  // reset value matches the filter reset so the two never disagree after reset
  localparam int         FINE_N    = 2;
  localparam int         FILT_STEP = CSC_R2F_LSB - CSC_R1F_LSB;
  localparam logic [1:0] FINE_RST  = {(CSC_FILTER_RST[CSC_R2F_LSB +: 2] != CSC_FILT_OFF),
                                      (CSC_FILTER_RST[CSC_R1F_LSB +: 2] != CSC_FILT_OFF)};

  logic [FINE_N-1:0] fine_q;
  logic [FINE_N-1:0] fine_d;

  for (genvar g = 0; g < FINE_N; g++) begin : g_fine
    // reserved code 10 counts as filter on
    assign fine_d[g] = (filt_d[CSC_R1F_LSB + g * FILT_STEP +: 2] != CSC_FILT_OFF);
  end

  always_ff @(posedge i_ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      fine_q <= FINE_RST;
    end else begin
      fine_q <= fine_d;
    end
  end

  assign o_reg_rdata             = rdata_q;
  assign o_conv_start            = start_q;
  assign o_conv_chan             = ch_q;
  assign o_busy                  = busy_q;
  assign o_standby               = standby_q;
  assign o_rate_select           = rate_q;
  assign o_remote_one_filter_sel = filt_q[CSC_R1F_LSB +: 2];
  assign o_remote_two_filter_sel = filt_q[CSC_R2F_LSB +: 2];
  assign o_fine_bits_en          = fine_q;

endmodule

/* File: verilog/csc_pkg.sv */
// package: command bytes, field layout, reset values and timing of the sequencer
package csc_pkg;

  // ----------------------------------------------------------------
  // command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CSC_CMD_STATUS    = 8'h02;
  localparam logic [7:0] CSC_CMD_CONFIG    = 8'h03;
  localparam logic [7:0] CSC_CMD_INTERVAL  = 8'h04;
  localparam logic [7:0] CSC_CMD_CHAN_EN   = 8'h05;
  localparam logic [7:0] CSC_CMD_FILTER    = 8'h06;
  localparam logic [7:0] CSC_CMD_ONE_SHOT  = 8'h0f;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CSC_STANDBY_BIT = 6;
  localparam int CSC_BUSY_BIT    = 7;
  localparam int CSC_RATE_W      = 2;
  localparam int CSC_CHAN_N      = 3;
  localparam int CSC_FILT_W      = 4;
  localparam int CSC_R1F_LSB     = 0;
  localparam int CSC_R2F_LSB     = 2;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] CSC_CONFIG_RST   = 8'h00;
  localparam logic [7:0] CSC_INTERVAL_RST = 8'h02;
  localparam logic [7:0] CSC_CHAN_EN_RST  = 8'h1f;
  localparam logic [7:0] CSC_FILTER_RST   = 8'h0f;

  // ----------------------------------------------------------------
  // rate codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] CSC_RATE_CONT = 2'h0;
  localparam logic [1:0] CSC_RATE_364  = 2'h1;
  localparam logic [1:0] CSC_RATE_1S   = 2'h2;
  localparam logic [1:0] CSC_RATE_2S5  = 2'h3;
  localparam logic [1:0] CSC_FILT_OFF  = 2'h0;

  localparam longint CSC_CLK_KHZ       = 250000;
  localparam longint CSC_IVL_364_MS    = 364;
  localparam longint CSC_IVL_1S_MS     = 1000;
  localparam longint CSC_IVL_2S5_MS    = 2500;
  localparam longint CSC_IVL_364_CYC   = CSC_IVL_364_MS * CSC_CLK_KHZ;
  localparam longint CSC_IVL_1S_CYC    = CSC_IVL_1S_MS * CSC_CLK_KHZ;
  localparam longint CSC_IVL_2S5_CYC   = CSC_IVL_2S5_MS * CSC_CLK_KHZ;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } csc_reg_req_t;

  typedef enum logic [1:0] {
    CSC_ST_IDLE,
    CSC_ST_CONV,
    CSC_ST_WAIT
  } csc_state_t;

endpackage

/* File: verification/csc_conv_model.sv */
// partner model: converter that answers each start pulse after a fixed delay
module csc_conv_model #(
  parameter int DLY = 12
) (
  input  wire logic i_ref_clk,
  input  wire logic i_start,
  output logic      o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q = 0;
  // falling edge so the sequencer samples a settled pulse
  always @(negedge i_ref_clk) begin
    o_done <= (cnt_q == 1);
    if (i_start) cnt_q <= DLY;
    else if (cnt_q != 0) cnt_q <= cnt_q - 1;
  end
endmodule

/* File: verification/csc_seq_chk.sv */
// checker: port relations of the conversion sequencer
module csc_seq_chk
  import csc_pkg::*;
(
  input wire logic         i_ref_clk,
  input wire logic         i_rst_b,
  input wire csc_reg_req_t i_reg_req,
  input wire logic         i_conv_done,
  input wire logic [7:0]   o_reg_rdata,
  input wire logic         o_conv_start,
  input wire logic [1:0]   o_conv_chan,
  input wire logic         o_busy,
  input wire logic         o_standby,
  input wire logic [1:0]   o_rate_select,
  input wire logic [1:0]   o_remote_one_filter_sel,
  input wire logic [1:0]   o_remote_two_filter_sel,
  input wire logic [1:0]   o_fine_bits_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // settle window: the sequencer leaves reset two edges after the pin
  // ----------------------------------------------------------------
  logic [2:0] up_q;
  logic [2:0] up_d;
  logic       rd_ev;
  logic       trig;
  assign rd_ev = i_reg_req.rd;
  assign trig  = i_reg_req.wr && (i_reg_req.cmd == CSC_CMD_ONE_SHOT);
  always_comb up_d = (up_q == 3'h4) ? up_q : up_q + 3'h1;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) up_q <= 3'h0;
    else up_q <= up_d;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b || up_q != 3'h4);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_FINE_ONE: assert property (o_fine_bits_en[0] == (o_remote_one_filter_sel != 2'h0))
    else $error("remote one fine bits disagree with filter");
  AST_FINE_TWO: assert property (o_fine_bits_en[1] == (o_remote_two_filter_sel != 2'h0))
    else $error("remote two fine bits disagree with filter");
  AST_START_BUSY: assert property (o_conv_start |-> o_busy)
    else $error("start pulse without busy");
  AST_DONE_NEXT: assert property (o_busy && i_conv_done |=> o_conv_start || !o_busy)
    else $error("no next channel or end of pass after done");
  AST_CHAN_UP: assert property (o_conv_start && $past(o_busy)
    |-> o_conv_chan > $past(o_conv_chan)) else $error("channel order not ascending");
  AST_CHAN_HOLD: assert property (o_busy && !o_conv_start |-> $stable(o_conv_chan))
    else $error("channel changed during conversion");
  AST_TRIG_RD: assert property (rd_ev && i_reg_req.cmd == CSC_CMD_ONE_SHOT
    |=> o_reg_rdata == 8'h00) else $error("trigger register read not zero");
  AST_RATE_RD: assert property (rd_ev && i_reg_req.cmd == CSC_CMD_INTERVAL
    |=> o_reg_rdata == {6'h00, $past(o_rate_select)}) else $error("rate readback wrong");
  AST_IDLE_STANDBY_REQUEST: assert property (o_standby && !o_busy && !trig |=> !o_conv_start)
    else $error("pass started in standby without trigger");
  COV_CHAN_TWO: cover property (o_conv_start && o_conv_chan == 2'h2);
  COV_PASS_END: cover property (o_standby && $fell(o_busy));
  COV_TRIG: cover property (trig && o_standby);
endmodule

bind csc_conversion_sequencer csc_seq_chk chk_u (.*);

/* File: verification/csc_conversion_sequencer_tb.sv */
// testbench: register access, pass timing and one-shot behaviour
module csc_conversion_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csc_pkg::*;
  localparam int P1  = 200;
  localparam int P2  = 400;
  localparam int P3  = 800;
  localparam int DLY = 12;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  csc_reg_req_t req = '0;
  logic [7:0]   rdata;
  logic         start, done, busy, standby_request;
  logic [1:0]   chan, rate, f1, f2, fine;
  logic [1:0]   seen[$];
  int           num_errors = 0;
  int           samples_checked = 0;

  always #2 clk = ~clk;
  always @(negedge clk) if (start === 1'b1) seen.push_back(chan);

  csc_conversion_sequencer #(.IVL_364_CYC(P1), .IVL_1S_CYC(P2), .IVL_2S5_CYC(P3)) dut_u (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_reg_req(req), .i_conv_done(done),
    .o_reg_rdata(rdata), .o_conv_start(start), .o_conv_chan(chan), .o_busy(busy),
    .o_standby(standby_request), .o_rate_select(rate), .o_remote_one_filter_sel(f1),
    .o_remote_two_filter_sel(f2), .o_fine_bits_en(fine));
  csc_conv_model #(.DLY(DLY)) conv_u (.i_ref_clk(clk), .i_start(start), .o_done(done));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] c, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: w, rd: !w, cmd: c, wdata: d};
    @(negedge clk);
    req = '0;
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [7:0] exp);
    bus(1'b0, c, 8'h00);
    check(rdata, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [1:0] code[3] = '{2'h0, 2'h1, 2'h3}; // reserved code never written
    rdchk(CSC_CMD_INTERVAL, 8'h02);
    rdchk(CSC_CMD_CHAN_EN, 8'h07);
    rdchk(CSC_CMD_FILTER, 8'h0f);
    rdchk(CSC_CMD_CONFIG, 8'h00);
    check({7'h0, standby_request}, 8'h00);
    for (int i = 0; i < 3; i++) bus(1'b1, CSC_CMD_INTERVAL + 8'(i), 8'hff);
    bus(1'b1, CSC_CMD_ONE_SHOT, 8'ha5);
    check({6'h0, rate}, 8'h03);
    rdchk(CSC_CMD_INTERVAL, 8'h03);
    rdchk(CSC_CMD_CHAN_EN, 8'h07);
    rdchk(CSC_CMD_FILTER, 8'h0f);
    rdchk(CSC_CMD_ONE_SHOT, 8'h00);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, CSC_CMD_FILTER, {4'h0, code[2 - i], code[i]});
      check({4'h0, f2, f1}, {4'h0, code[2 - i], code[i]});
      check({6'h0, fine}, {6'h0, code[2 - i] != 2'h0, code[i] != 2'h0});
    end
  endtask
  // spacing of pass starts, taken after two passes so new settings apply
  task automatic measure(input logic [1:0] code, input logic [7:0] en, input logic [1:0] lo,
                         input int lo_n, input int hi_n, input logic trig);
    int n;
    bus(1'b1, CSC_CMD_INTERVAL, {6'h0, code});
    bus(1'b1, CSC_CMD_CHAN_EN, en);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      if (trig && k == 2) begin
        bus(1'b1, CSC_CMD_ONE_SHOT, 8'h00);
        n = 2;
      end
      do begin
        @(negedge clk);
        n++;
      end while (!(start === 1'b1 && chan === lo));
    end
    check({7'h0, n >= lo_n && n <= hi_n}, 8'h01);
  endtask
  task automatic t_single();
    logic [1:0] exp[$];
    bus(1'b1, CSC_CMD_CONFIG, 8'h40);
    check({7'h0, standby_request}, 8'h01);
    rdchk(CSC_CMD_CONFIG, 8'h40);
    repeat (5 * DLY) @(negedge clk);
    seen.delete();
    repeat (P1 + 50) @(negedge clk);
    check(8'(seen.size()), 8'h00);
    for (int en = 0; en < 8; en++) begin
      bus(1'b1, CSC_CMD_CHAN_EN, 8'(en));
      seen.delete();
      exp.delete();
      bus(1'b1, CSC_CMD_ONE_SHOT, 8'h5a);
      bus(1'b0, CSC_CMD_STATUS, 8'h00);
      check({7'h0, rdata[7]}, {7'h0, en != 0});
      repeat (5 * DLY) @(negedge clk);
      for (int c = 0; c < 3; c++) if (en[c]) exp.push_back(2'(c));
      check(8'(seen.size()), 8'(exp.size()));
      foreach (exp[i]) check({6'h0, seen[i]}, {6'h0, exp[i]});
      check({7'h0, busy}, 8'h00);
    end
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_regs();
    measure(2'h1, 8'h07, 2'h0, P1, P1 + 1, 1'b0);
    measure(2'h2, 8'h07, 2'h0, P2, P2 + 1, 1'b0);
    measure(2'h3, 8'h07, 2'h0, P3, P3 + 1, 1'b1);
    measure(2'h1, 8'h06, 2'h1, P1, P1 + 1, 1'b0);
    measure(2'h0, 8'h07, 2'h0, 3 * DLY, 3 * DLY + 16, 1'b0);
    measure(2'h0, 8'h01, 2'h0, DLY, DLY + 8, 1'b0);
    t_single();
    finish_test();
  end
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule
